// ### verilog/cswt_params.svh
`ifndef CSWT_PARAMS_SVH
`define CSWT_PARAMS_SVH
// Overview of operation
// - Timer starts once a valid on-time is written, whatever else is set.
// - Sensed edge alerts host in Normal/Stop, wakes regulator in Sleep/Fail-Safe.
// - Off-low/off-high hold the mapped switch at that static level.
// - Set configuration error flag when on-time exceeds period.
// - First sample is the reference; a later differing sample wakes.
// - Filter starts at on-time end; input must stay stable to count.
// - Cyclic sense wake sets that input's wake event flag.
// - Level snapshot takes sampled levels only in Normal/Stop; static inputs load the live level.
// - Fail-Safe turns sensing switches off, inputs go to static sensing.
// - Switch faults in Normal/Stop/Sleep turn the mapped switch off.
// - Timers keep running after a fault turns their switch off.
// - Sense wake interrupts in Stop, restarts device from Sleep.
// - Sleep request with pending flags restarts at once with reset.
// - Timer enabled as wake source interrupts in Normal and Stop.
// - Cyclic wake interrupts at each on-time start except the first.
// - Period selects 10, 20, 50, 100, 200 ms, 1 s or 2 s.
// - On-time selects 0.1, 0.3, 1, 10, 20 ms or off high/low.
// - Either timer can be mapped to any high-side switch.

`define CSWT_ADDR_W 4
`define CSWT_DATA_W 8
`define CSWT_A_TMR1 4'h0
`define CSWT_A_TMR2 4'h1
`define CSWT_A_WKEN 4'h2
`define CSWT_A_HSMAP 4'h3
`define CSWT_A_WKCFG 4'h4
`define CSWT_A_STATA 4'h5
`define CSWT_A_STATB 4'h6
`define CSWT_A_SNAP 4'h7
`define CSWT_A_ERR 4'h8

`define CSWT_CLK_MHZ 100
`define CSWT_TICK_US 10
`define CSWT_TICK_CYC (`CSWT_TICK_US * `CSWT_CLK_MHZ)
`define CSWT_FILT_NS 16000
`define CSWT_FILT_CYC ((`CSWT_FILT_NS * `CSWT_CLK_MHZ + 999) / 1000)

`define CSWT_PER0_MS 10
`define CSWT_PER1_MS 20
`define CSWT_PER2_MS 50
`define CSWT_PER3_MS 100
`define CSWT_PER4_MS 200
`define CSWT_PER5_MS 1000
`define CSWT_PER6_MS 2000
`define CSWT_ON2_US 100
`define CSWT_ON3_US 300
`define CSWT_ON4_US 1000
`define CSWT_ON5_US 10000
`define CSWT_ON6_US 20000
`define CSWT_OT_OFF_LOW 3'h0
`define CSWT_OT_OFF_HIGH 3'h1
`define CSWT_OT_LAST 3'h6
`define CSWT_CNT_W 18
`endif

// ### verilog/cswt_pkg.sv
package cswt_pkg;
  typedef enum logic [1:0] {
    CSWT_NORMAL = 2'h0,
    CSWT_STOP = 2'h1,
    CSWT_SLEEP = 2'h2,
    CSWT_FAILSAFE = 2'h3
  } cswt_mode_t;
  typedef struct packed {
    logic [2:0] ontime;
    logic [2:0] period;
  } cswt_tmr_cfg_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } cswt_bus_req_t;
endpackage

// ### verilog/cswt_top.sv
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`include "cswt_params.svh"
module cswt_top #(
  parameter int TICK_CYC = `CSWT_TICK_CYC,
  parameter int FILT_CYC = `CSWT_FILT_CYC,
  parameter int NUM_HS = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire cswt_pkg::cswt_bus_req_t bus_req,
  output logic [`CSWT_DATA_W-1:0] rd_data,
  input wire cswt_pkg::cswt_mode_t mode,
  input wire logic sleep_req,
  input wire logic [2:0] wake_input_pin,
  input wire logic [NUM_HS-1:0] hs_fault,
  output logic [NUM_HS-1:0] highside_switch_out,
  output logic host_alert_n,
  output logic main_regulator_output_wake,
  output logic restart_req,
  output logic reset_req
);
  localparam int CW = `CSWT_CNT_W;

  if (TICK_CYC < 1 || TICK_CYC > 65536 || FILT_CYC < 2 ||
      FILT_CYC > 65536 || NUM_HS < 1 || NUM_HS > 4) begin : g_chk
    $error("cswt_top: unsupported parameter values");
  end

  function automatic logic [CW-1:0] per_ticks(input logic [2:0] s);
    case (s)
      3'h1: per_ticks = CW'(`CSWT_PER1_MS * 1000 / `CSWT_TICK_US);
      3'h2: per_ticks = CW'(`CSWT_PER2_MS * 1000 / `CSWT_TICK_US);
      3'h3: per_ticks = CW'(`CSWT_PER3_MS * 1000 / `CSWT_TICK_US);
      3'h4: per_ticks = CW'(`CSWT_PER4_MS * 1000 / `CSWT_TICK_US);
      3'h5: per_ticks = CW'(`CSWT_PER5_MS * 1000 / `CSWT_TICK_US);
      3'h6: per_ticks = CW'(`CSWT_PER6_MS * 1000 / `CSWT_TICK_US);
      default: per_ticks = CW'(`CSWT_PER0_MS * 1000 / `CSWT_TICK_US);
    endcase
  endfunction

  function automatic logic [CW-1:0] on_ticks(input logic [2:0] s);
    case (s)
      3'h2: on_ticks = CW'(`CSWT_ON2_US / `CSWT_TICK_US);
      3'h3: on_ticks = CW'(`CSWT_ON3_US / `CSWT_TICK_US);
      3'h4: on_ticks = CW'(`CSWT_ON4_US / `CSWT_TICK_US);
      3'h5: on_ticks = CW'(`CSWT_ON5_US / `CSWT_TICK_US);
      3'h6: on_ticks = CW'(`CSWT_ON6_US / `CSWT_TICK_US);
      default: on_ticks = '0;
    endcase
  endfunction

  logic wr_tmr [2];
  logic [1:0] tmr_start;
  logic [1:0] tmr_run;
  logic [1:0] tmr_win;
  logic [1:0] tmr_wrap;
  logic [1:0] tmr_end;
  logic [1:0] tmr_lvl;
  logic [1:0] tmr_err;
  cswt_pkg::cswt_tmr_cfg_t tcfg [2];
  logic [1:0] wk_src_en;
  logic [2*NUM_HS-1:0] hs_map;
  logic [2:0] cs_en;
  logic [2:0] cs_tsel;
  logic [2:0] stat_a;
  logic [1:0] stat_b;
  logic [2:0] snap;
  logic cfg_err;
  logic [NUM_HS-1:0] hs_off;
  logic [2:0] wk_ev;
  logic [2:0] wk_snap_ld;
  logic [2:0] wk_snap_val;
  logic [1:0] tmr_ev;
  logic active_mode;
  logic low_power;

  assign active_mode = mode == cswt_pkg::CSWT_NORMAL ||
                       mode == cswt_pkg::CSWT_STOP;
  assign low_power = mode == cswt_pkg::CSWT_SLEEP ||
                     mode == cswt_pkg::CSWT_FAILSAFE;
  assign wr_tmr[0] = bus_req.wr && bus_req.addr == `CSWT_A_TMR1;
  assign wr_tmr[1] = bus_req.wr && bus_req.addr == `CSWT_A_TMR2;

  // Configuration registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wk_src_en <= '0;
      hs_map <= '0;
      cs_en <= '0;
      cs_tsel <= '0;
    end else if (bus_req.wr) begin
      case (bus_req.addr)
        `CSWT_A_WKEN: wk_src_en <= bus_req.wdata[1:0];
        `CSWT_A_HSMAP: hs_map <= bus_req.wdata[2*NUM_HS-1:0];
        `CSWT_A_WKCFG: begin
          cs_en <= bus_req.wdata[2:0];
          cs_tsel <= bus_req.wdata[6:4];
        end
        default: ;
      endcase
    end
  end

  for (genvar t = 0; t < 2; t++) begin : g_tmr
    logic [CW-1:0] cnt;
    logic [CW-1:0] per;
    logic [CW-1:0] ont;
    logic [2:0] new_ot;
    logic [2:0] new_per;
    logic [15:0] pre;
    logic tk;
    assign new_ot = bus_req.wdata[6:4];
    assign new_per = bus_req.wdata[2:0];
    assign per = per_ticks(tcfg[t].period);
    assign ont = on_ticks(tcfg[t].ontime);
    // Valid on-time written starts the timer
    assign tmr_start[t] = wr_tmr[t] && new_ot > `CSWT_OT_OFF_HIGH &&
                          new_ot <= `CSWT_OT_LAST;
    assign tmr_err[t] = tmr_start[t] &&
                        on_ticks(new_ot) > per_ticks(new_per);
    assign tmr_run[t] = tcfg[t].ontime > `CSWT_OT_OFF_HIGH &&
                        tcfg[t].ontime <= `CSWT_OT_LAST;

    always_ff @(posedge clk) begin
      if (sys_rst) begin
        tcfg[t] <= '0;
      end else if (wr_tmr[t]) begin
        tcfg[t] <= {new_ot, new_per};
      end
    end

    // Own divider per timer, so a start always opens with a full tick
    // and the first window is as long as every later one
    always_ff @(posedge clk) begin
      if (sys_rst || tmr_start[t] || !tmr_run[t] ||
          pre == 16'(TICK_CYC - 1)) begin
        pre <= '0;
      end else begin
        pre <= pre + 16'h0001;
      end
    end
    assign tk = pre == 16'(TICK_CYC - 1);

    // Free running in period; fault switch-off does not stop it
    always_ff @(posedge clk) begin
      if (sys_rst || tmr_start[t] || !tmr_run[t]) begin
        cnt <= '0;
      end else if (tk) begin
        cnt <= (cnt == per - 1'b1) ? '0 : cnt + 1'b1;
      end
    end
    assign tmr_wrap[t] = tmr_run[t] && tk && cnt == per - 1'b1 &&
                         !wr_tmr[t];
    assign tmr_end[t] = tmr_run[t] && tk && cnt == ont - 1'b1 &&
                        ont < per && !wr_tmr[t];
    assign tmr_win[t] = tmr_run[t] && cnt < ont;
    assign tmr_lvl[t] = tmr_run[t] ? tmr_win[t] :
                        tcfg[t].ontime == `CSWT_OT_OFF_HIGH;
    // Start of each on-time after the first one
    assign tmr_ev[t] = tmr_wrap[t] && wk_src_en[t] && active_mode;
  end

  // High-side switches
  for (genvar h = 0; h < NUM_HS; h++) begin : g_hs
    logic [1:0] sel;
    assign sel = hs_map[2*h +: 2];
    // Outside Fail-Safe, a fault wins over a clearing map write in the same cycle
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        hs_off[h] <= 1'b0;
      end else if (hs_fault[h] && mode != cswt_pkg::CSWT_FAILSAFE) begin
        hs_off[h] <= 1'b1;
      end else if (bus_req.wr && bus_req.addr == `CSWT_A_HSMAP) begin
        hs_off[h] <= 1'b0;
      end
    end
    always_ff @(posedge clk) begin
      if (sys_rst || hs_off[h] ||
          mode == cswt_pkg::CSWT_FAILSAFE) begin
        highside_switch_out[h] <= 1'b0;
      end else begin
        unique case (sel)
          2'h1: highside_switch_out[h] <= tmr_lvl[0];
          2'h2: highside_switch_out[h] <= tmr_lvl[1];
          default: highside_switch_out[h] <= 1'b0;
        endcase
      end
    end
  end

  // Wake inputs: sync, sample, filter, compare
  for (genvar i = 0; i < 3; i++) begin : g_wk
    logic s1;
    logic s2;
    logic s3;
    logic stable;
    logic ref_lvl;
    logic have_ref;
    logic busy;
    logic cap;
    logic acc;
    logic trig;
    logic cyc;
    logic [15:0] fcnt;
    assign cyc = cs_en[i] && mode != cswt_pkg::CSWT_FAILSAFE;
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        s1 <= 1'b0;
        s2 <= 1'b0;
        s3 <= 1'b0;
        stable <= 1'b0;
      end else begin
        s1 <= wake_input_pin[i];
        s2 <= s1;
        s3 <= s2;
        if (s2 == s3) begin
          stable <= s3;
        end
      end
    end
    // Cyclic: end of on-time; Fail-Safe: static level change
    assign trig = !busy && (cyc ? tmr_end[cs_tsel[i]] :
                  (mode == cswt_pkg::CSWT_FAILSAFE && have_ref &&
                   stable != ref_lvl));
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        busy <= 1'b0;
        cap <= 1'b0;
        fcnt <= '0;
      end else if (trig) begin
        busy <= 1'b1;
        cap <= stable;
        fcnt <= '0;
      end else if (busy) begin
        if (stable != cap || fcnt == 16'(FILT_CYC - 1)) begin
          busy <= 1'b0;
        end
        fcnt <= fcnt + 16'h0001;
      end
    end
    assign acc = busy && stable == cap && fcnt == 16'(FILT_CYC - 1);
    always_ff @(posedge clk) begin
      if (sys_rst || (!cs_en[i] && mode != cswt_pkg::CSWT_FAILSAFE) ||
          (cyc && tmr_start[cs_tsel[i]])) begin
        have_ref <= 1'b0;
        ref_lvl <= 1'b0;
      end else if (mode == cswt_pkg::CSWT_FAILSAFE && !have_ref) begin
        have_ref <= 1'b1;
        ref_lvl <= stable;
      end else if (acc) begin
        have_ref <= 1'b1;
        ref_lvl <= cap;
      end
    end
    assign wk_ev[i] = acc && have_ref && cap != ref_lvl;
    assign wk_snap_ld[i] = cyc ? (acc && active_mode) : 1'b1;
    assign wk_snap_val[i] = cyc ? cap : stable;
  end

  // Status flags; a setting event wins over a clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stat_a <= '0;
      stat_b <= '0;
      cfg_err <= 1'b0;
    end else begin
      stat_a <= (stat_a & ~((bus_req.wr && bus_req.addr == `CSWT_A_STATA) ?
                bus_req.wdata[2:0] : 3'h0)) | wk_ev;
      stat_b <= (stat_b & ~((bus_req.wr && bus_req.addr == `CSWT_A_STATB) ?
                bus_req.wdata[1:0] : 2'h0)) | tmr_ev;
      cfg_err <= (cfg_err && !(bus_req.wr && bus_req.addr == `CSWT_A_ERR &&
                 bus_req.wdata[0])) || (|tmr_err);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      snap <= '0;
    end else begin
      for (int k = 0; k < 3; k++) begin
        if (wk_snap_ld[k]) begin
          snap[k] <= wk_snap_val[k];
        end
      end
    end
  end

  // Host alert, regulator wake, restart and reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      host_alert_n <= 1'b1;
      main_regulator_output_wake <= 1'b0;
      restart_req <= 1'b0;
      reset_req <= 1'b0;
    end else begin
      host_alert_n <= !(active_mode && ((|wk_ev) || (|tmr_ev)));
      main_regulator_output_wake <= low_power && (|wk_ev);
      restart_req <= (low_power && (|wk_ev)) ||
                     (sleep_req && ((|stat_a) || (|stat_b)));
      reset_req <= sleep_req && ((|stat_a) || (|stat_b));
    end
  end

  // Register read, data one cycle after the strobe
  always_ff @(posedge clk) begin
    if (sys_rst || !bus_req.rd) begin
      rd_data <= '0;
    end else begin
      case (bus_req.addr)
        `CSWT_A_TMR1: rd_data <= {1'b0, tcfg[0].ontime, 1'b0,
                                  tcfg[0].period};
        `CSWT_A_TMR2: rd_data <= {1'b0, tcfg[1].ontime, 1'b0,
                                  tcfg[1].period};
        `CSWT_A_WKEN: rd_data <= {6'h00, wk_src_en};
        `CSWT_A_HSMAP: rd_data <= 8'(hs_map);
        `CSWT_A_WKCFG: rd_data <= {1'b0, cs_tsel, 1'b0, cs_en};
        `CSWT_A_STATA: rd_data <= {5'h00, stat_a};
        `CSWT_A_STATB: rd_data <= {6'h00, stat_b};
        `CSWT_A_SNAP: rd_data <= {5'h00, snap};
        `CSWT_A_ERR: rd_data <= {2'h0, tmr_run, 3'h0, cfg_err};
        default: rd_data <= '0;
      endcase
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_start;
    tmr_start[0] |=> tmr_win[0] ##1 tmr_run[0];
  endproperty
  a_start: assert property (p_start) else $error("timer not started");

  property p_err;
    (|tmr_err) |=> cfg_err;
  endproperty
  a_err: assert property (p_err) else $error("config error missed");

  property p_static;
    (hs_map[1:0] == 2'h1 && !hs_off[0] && !tmr_run[0] &&
     mode != cswt_pkg::CSWT_FAILSAFE &&
     tcfg[0].ontime == `CSWT_OT_OFF_HIGH) [*2] |-> highside_switch_out[0];
  endproperty
  a_static: assert property (p_static) else $error("static level lost");

  property p_fs;
    mode == cswt_pkg::CSWT_FAILSAFE |=> highside_switch_out == '0;
  endproperty
  a_fs: assert property (p_fs) else $error("switch on in fail-safe");

  property p_fault;
    hs_fault[0] && mode != cswt_pkg::CSWT_FAILSAFE &&
    !(bus_req.wr && bus_req.addr == `CSWT_A_HSMAP)
    |=> ##1 !highside_switch_out[0];
  endproperty
  a_fault: assert property (p_fault) else $error("faulted switch on");

  property p_flag;
    wk_ev[0] |=> stat_a[0] ##1 (stat_a[0] || $past(bus_req.wr));
  endproperty
  a_flag: assert property (p_flag) else $error("wake flag not set");

  property p_alert;
    (|wk_ev) && active_mode |=> !host_alert_n ##1 host_alert_n ||
    $past(wk_ev) != 3'h0 || $past(tmr_ev) != 2'h0;
  endproperty
  a_alert: assert property (p_alert) else $error("alert missing");

  property p_win;
    hs_map[1:0] == 2'h1 && !hs_off[0] && tmr_run[0] &&
    mode != cswt_pkg::CSWT_FAILSAFE
    |=> highside_switch_out[0] == $past(tmr_win[0]);
  endproperty
  a_win: assert property (p_win) else $error("switch left window");

  property p_sleep;
    sleep_req && (|stat_a) |=> reset_req && restart_req;
  endproperty
  a_sleep: assert property (p_sleep) else $error("pending wake lost");
endmodule

// ### tb/cswt_sense_model.sv
`timescale 1ns/1ps
module cswt_sense_model (
  input wire logic clk,
  input wire logic hs_on,
  input wire logic [2:0] contact,
  output logic [2:0] wake_input_pin,
  output int on_len,
  output int per_len
);
  int run = 0;
  int since = 0;
  logic last = 1'b0;
  // Battery-fed pull-ups hold the contact level while the driver is off
  assign wake_input_pin = contact;
  // Width of the last switch window and spacing of its rising edges
  always @(posedge clk) begin
    last <= hs_on;
    since <= (hs_on && !last) ? 1 : since + 1;
    run <= hs_on ? run + 1 : 0;
    if (!hs_on && last) begin
      on_len <= run;
    end
    if (hs_on && !last) begin
      per_len <= since;
    end
  end
endmodule

// ### tb/test_cswt_top.sv
`timescale 1ns/1ps
`include "cswt_params.svh"
module test_cswt_top;
  localparam int TK = 2;
  localparam int FC = 4;
  localparam int PCYC = 1000 * TK;
  localparam logic [2:0] ONT [5] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
  localparam logic [2:0] PER [5] = '{3'h0, 3'h0, 3'h0, 3'h1, 3'h2};
  localparam int OLEN [5] = '{10, 30, 100, 1000, 2000};
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  cswt_pkg::cswt_bus_req_t bus_req = '0;
  cswt_pkg::cswt_mode_t mode = cswt_pkg::CSWT_NORMAL;
  logic sleep_req = 1'b0;
  logic [3:0] hs_fault = 4'h0;
  logic [2:0] contact = 3'h7;
  logic [7:0] rd_data;
  logic [2:0] wake_input_pin;
  logic [3:0] highside_switch_out;
  logic host_alert_n;
  logic main_regulator_output_wake;
  logic restart_req;
  logic reset_req;
  int on_len;
  int per_len;
  int error_cnt = 0;
  int check_count = 0;
  int n;
  logic [7:0] v;

  always #5 clk = ~clk;

  cswt_top #(.TICK_CYC(TK), .FILT_CYC(FC), .NUM_HS(4)) dut (
    .clk(clk), .sys_rst(sys_rst), .bus_req(bus_req), .rd_data(rd_data),
    .mode(mode), .sleep_req(sleep_req), .wake_input_pin(wake_input_pin),
    .hs_fault(hs_fault), .highside_switch_out(highside_switch_out),
    .host_alert_n(host_alert_n),
    .main_regulator_output_wake(main_regulator_output_wake),
    .restart_req(restart_req), .reset_req(reset_req)
  );

  cswt_sense_model model (
    .clk(clk), .hs_on(highside_switch_out[0]), .contact(contact),
    .wake_input_pin(wake_input_pin), .on_len(on_len), .per_len(per_len)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    bus_req <= '0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    bus_req <= '0;
    #1;
    d = rd_data;
  endtask

  function automatic logic ev(input int k);
    case (k)
      0: return ~host_alert_n;
      1: return restart_req;
      2: return main_regulator_output_wake;
      default: return reset_req;
    endcase
  endfunction

  // Cycles until the chosen pulse shows, -1 if it does not show within lim cycles
  task automatic wait_ev(input int k, input int lim, output int cyc);
    cyc = -1;
    for (int i = 1; i <= lim && cyc < 0; i++) begin
      @(posedge clk);
      #1;
      if (ev(k) === 1'b1) cyc = i;
    end
  endtask

  task automatic count_hi(input int cyc, output int cnt);
    cnt = 0;
    repeat (cyc) begin
      @(posedge clk);
      #1;
      if (highside_switch_out[0] === 1'b1) cnt++;
    end
  endtask

  task automatic pulse_sleep();
    @(posedge clk);
    sleep_req <= 1'b1;
    @(posedge clk);
    sleep_req <= 1'b0;
  endtask

  task automatic t_reset();
    rd(`CSWT_A_ERR, v);
    check(v, 8'h00);
    check(highside_switch_out, 4'h0);
    check(host_alert_n, 1'b1);
  endtask

  task automatic t_window();
    wr(`CSWT_A_TMR1, 8'h10);
    wr(`CSWT_A_HSMAP, 8'h01);
    repeat (3) @(posedge clk);
    #1;
    check(highside_switch_out, 4'h1);
    wr(`CSWT_A_TMR1, 8'h00);
    repeat (3) @(posedge clk);
    #1;
    check(highside_switch_out, 4'h0);
    wr(`CSWT_A_WKCFG, 8'h01);
    for (int i = 0; i < 5; i++) begin
      wr(`CSWT_A_TMR1, {1'b0, ONT[i], 1'b0, PER[i]});
      repeat (OLEN[i] * TK + 10) @(posedge clk);
      check(on_len, OLEN[i] * TK);
    end
    wr(`CSWT_A_TMR1, 8'h20);
    repeat (PCYC + 100) @(posedge clk);
    check(per_len, PCYC);
    wr(`CSWT_A_TMR2, 8'h20);
    rd(`CSWT_A_ERR, v);
    check(v[5:4], 2'h3);
    wr(`CSWT_A_TMR2, 8'h00);
  endtask

  task automatic t_err();
    for (int p = 0; p < 7; p++) begin
      wr(`CSWT_A_TMR2, {4'h6, 1'b0, 3'(p)});
      rd(`CSWT_A_ERR, v);
      check(v[0], p == 0);
      wr(`CSWT_A_ERR, 8'h01);
    end
    wr(`CSWT_A_TMR2, 8'h50);
    rd(`CSWT_A_ERR, v);
    check(v[0], 1'b0);
    wr(`CSWT_A_TMR2, 8'h00);
  endtask

  task automatic t_sense();
    @(posedge clk);
    mode <= cswt_pkg::CSWT_STOP;
    contact[0] <= 1'b0;
    wait_ev(0, 3 * PCYC, n);
    check(n > 0, 1'b1);
    rd(`CSWT_A_STATA, v);
    check(v[2:0], 3'h1);
    rd(`CSWT_A_SNAP, v);
    check(v[0], 1'b0);
    wr(`CSWT_A_STATA, 8'h01);
    rd(`CSWT_A_STATA, v);
    check(v[2:0], 3'h0);
  endtask

  task automatic t_sleep();
    @(posedge clk);
    mode <= cswt_pkg::CSWT_SLEEP;
    contact[0] <= 1'b1;
    wait_ev(1, 3 * PCYC, n);
    check(main_regulator_output_wake, 1'b1);
    check(host_alert_n, 1'b1);
    @(posedge clk);
    mode <= cswt_pkg::CSWT_NORMAL;
    rd(`CSWT_A_SNAP, v);
    check(v[0], 1'b0);
    pulse_sleep();
    #1;
    check(restart_req, 1'b1);
    check(reset_req, 1'b1);
    wr(`CSWT_A_STATA, 8'h07);
    wr(`CSWT_A_STATB, 8'h03);
    pulse_sleep();
    #1;
    check(reset_req, 1'b0);
    wait_ev(3, 4, n);
    check(n, -1);
  endtask

  task automatic t_wake();
    wr(`CSWT_A_TMR1, 8'h00);
    wr(`CSWT_A_WKEN, 8'h01);
    wr(`CSWT_A_TMR1, 8'h20);
    wait_ev(0, PCYC + 50, n);
    check(n > PCYC - 100 && n <= PCYC, 1'b1);
    rd(`CSWT_A_STATB, v);
    check(v[1:0], 2'h1);
    @(posedge clk);
    mode <= cswt_pkg::CSWT_STOP;
    wait_ev(0, PCYC + 50, n);
    check(n > 0, 1'b1);
    @(posedge clk);
    mode <= cswt_pkg::CSWT_NORMAL;
    wr(`CSWT_A_WKEN, 8'h00);
  endtask

  task automatic t_fault();
    @(posedge clk);
    hs_fault[0] <= 1'b1;
    repeat (3) @(posedge clk);
    count_hi(PCYC, n);
    check(n, 0);
    rd(`CSWT_A_ERR, v);
    check(v[4], 1'b1);
    @(posedge clk);
    hs_fault[0] <= 1'b0;
    wr(`CSWT_A_HSMAP, 8'h01);
    count_hi(PCYC, n);
    check(n, 10 * TK);
    @(posedge clk);
    mode <= cswt_pkg::CSWT_FAILSAFE;
    repeat (3) @(posedge clk);
    count_hi(PCYC, n);
    check(n, 0);
    @(posedge clk);
    contact[1] <= 1'b0;
    wait_ev(2, 200, n);
    check(n > 0, 1'b1);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    $display("test reset done");
    t_window();
    $display("test window done");
    t_err();
    $display("test config error done");
    t_sense();
    $display("test cyclic sense done");
    t_sleep();
    $display("test sleep wake done");
    t_wake();
    $display("test cyclic wake done");
    t_fault();
    $display("test fault done");
    print_verdict();
  end

  initial begin
    #600000;
    error_cnt++;
    print_verdict();
  end
endmodule
